// [gctc_dev.sv]
// Converter end: gated down-counter, slope accumulator and command decoder.
`timescale 1ns/1ps
module gctc_dev
  import gctc_pkg::*;
(
  input  wire logic       clk,       // System clock.
  input  wire logic       sys_rst,   // Synchronous reset, active high.
  input  wire logic       ce,        // Clock enable, freezes all state when low.
  input  wire logic       ref_tick,  // One-cycle tick of the stable oscillator.
  input  wire logic       gate,      // Gate level from the temperature oscillator.
  input  wire gctc_var_t  variant,   // Command set in use.
  output logic            busy,      // Conversion in progress.
  gctc_if.dev             bus        // Command channel.
);
  typedef enum logic [1:0] {
    GCTC_IDLE  = 2'b00,
    GCTC_ARM   = 2'b01,
    GCTC_COUNT = 2'b11,
    GCTC_CALC  = 2'b10
  } gctc_st_t;

  gctc_st_t   st_r;
  logic [8:0] cnt_r;
  logic [8:0] slope_r;
  logic [7:0] deg_r;
  logic [8:0] temp_r;
  logic [7:0] temp8_r;
  logic       done_r;
  logic       busy_r;
  logic       pfx_r;
  logic [7:0] pfx_byte_r;
  logic       rsp_valid_r;
  logic [8:0] rsp_data_r;

  // Command decode; a prefix byte is remembered so the pair acts as one command.
  wire        is_bm     = (variant == GCTC_VBM);
  wire        cmd       = bus.cmd_valid;
  wire [7:0]  cb        = bus.cmd_byte;
  wire        cnt_pair  = pfx_r && (pfx_byte_r == CMD_CNT_PFX);
  wire        temp_pair = pfx_r && (pfx_byte_r == CMD_TEMP_PFX);
  wire        take_pfx  = cmd && is_bm && !pfx_r &&
                          ((cb == CMD_CNT_PFX) || (cb == CMD_TEMP_PFX));
  wire        do_start  = cmd && (is_bm ? (cb == CMD_START_BM && !pfx_r) : cb == CMD_START);
  wire        do_rtemp  = cmd && (is_bm ? (temp_pair && cb == CMD_TEMP_BM) : cb == CMD_RD_TEMP);
  wire        do_rcnt   = cmd && (is_bm ? (cnt_pair && cb == CMD_RD_CNT) : cb == CMD_RD_CNT);
  wire        do_load   = cmd && (is_bm ? (cnt_pair && cb == CMD_LOAD_CNT) : cb == CMD_LOAD_CNT);

  // Fraction of the last degree is (slope - residual) / slope.
  wire        cnt_over  = cnt_r > slope_r;
  wire [10:0] diff4     = cnt_over ? 11'h000 : {(slope_r - cnt_r), 2'b00};
  wire [10:0] slope1    = {2'b00, slope_r};
  wire [10:0] slope3    = {1'b0, slope_r, 1'b0} + {2'b00, slope_r};
  wire [10:0] slope2    = {1'b0, slope_r, 1'b0};
  wire        frac_half = diff4 >= slope1;
  wire        frac_up   = diff4 >= slope3;
  wire        frac_up8  = diff4 >= slope2;
  wire [8:0]  deg_half  = {deg_r, 1'b0};
  wire [8:0]  max_half  = {DEG_MAX, 1'b0};
  wire [8:0]  rnd_half  = frac_up ? deg_half + HALF_TWO :
                          frac_half ? deg_half + HALF_ONE : deg_half;
  wire        at_max    = (deg_r == DEG_MAX);
  wire [8:0]  temp_nxt  = at_max ? max_half : rnd_half;
  wire [7:0]  temp8_nxt = (frac_up8 && !at_max) ? deg_r + DEG_ONE : deg_r;
  wire        gate_on   = (st_r == GCTC_COUNT) && gate && ref_tick;
  wire        zero_hit  = gate_on && (cnt_r == 9'h000);

  // Response selection.
  // Nine-bit half-degree temperature for V9, sign-extended byte for V8 and VBM
  wire [8:0]  temp_sel  = (variant == GCTC_V9) ? temp_r :
                          (variant == GCTC_V8) ? {temp8_r[7], temp8_r} :
                          {temp_r[7], temp_r[7:0]};
  wire [8:0]  rsp_sel   = do_rcnt ? cnt_r : temp_sel;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= GCTC_IDLE;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce) begin
      case (st_r)
        GCTC_IDLE: begin
          if (do_start) begin
            st_r <= GCTC_ARM;
            done_r <= 1'b0;
            busy_r <= 1'b1;
          end
        end
        GCTC_ARM: begin
          if (gate) begin
            st_r <= GCTC_COUNT;
          end
        end
        GCTC_COUNT: begin
          if (!gate) begin
            st_r <= GCTC_CALC;
          end
        end
        GCTC_CALC: begin
          st_r <= GCTC_IDLE;
          done_r <= 1'b1;
          busy_r <= 1'b0;
        end
        default: begin
          st_r <= GCTC_IDLE;
        end
      endcase
    end
  end

  // A load during a conversion is ignored so the running count is not corrupted.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= CNT_BASE;
      slope_r <= SLOPE_BASE;
      deg_r <= DEG_MIN;
    end else if (ce) begin
      if (st_r == GCTC_IDLE && do_start) begin
        cnt_r <= CNT_BASE;
        slope_r <= SLOPE_BASE;
        deg_r <= DEG_MIN;
      end else if (zero_hit) begin
        cnt_r <= slope_r;
        slope_r <= slope_r + SLOPE_STEP;
        if (!at_max) begin
          deg_r <= deg_r + DEG_ONE;
        end
      end else if (gate_on) begin
        cnt_r <= cnt_r - CNT_ONE;
      end else if (do_load && !busy_r) begin
        cnt_r <= slope_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_r <= {DEG_MIN, 1'b0};
      temp8_r <= DEG_MIN;
    end else if (ce && st_r == GCTC_CALC) begin
      temp_r <= temp_nxt;
      temp8_r <= temp8_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pfx_r <= 1'b0;
      pfx_byte_r <= 8'h00;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 9'h000;
    end else if (ce) begin
      pfx_r <= take_pfx;
      if (take_pfx) begin
        pfx_byte_r <= cb;
      end
      rsp_valid_r <= do_rtemp || do_rcnt;
      if (do_rtemp || do_rcnt) begin
        rsp_data_r <= rsp_sel;
      end
    end
  end

  assign bus.rsp_valid = rsp_valid_r;
  assign bus.rsp_data  = rsp_data_r;
  assign bus.conv_done = done_r;
  assign busy          = busy_r;
endmodule

// [gctc_pkg.sv]
// Shared constants and types for the gated count temperature converter.
package gctc_pkg;
  // Command bytes.
  localparam logic [7:0] CMD_START     = 8'hee;
  localparam logic [7:0] CMD_RD_TEMP   = 8'haa;
  localparam logic [7:0] CMD_RD_CNT    = 8'ha0;
  localparam logic [7:0] CMD_LOAD_CNT  = 8'h41;
  localparam logic [7:0] CMD_START_BM  = 8'hd2;
  localparam logic [7:0] CMD_TEMP_PFX  = 8'hb2;
  localparam logic [7:0] CMD_TEMP_BM   = 8'h61;
  localparam logic [7:0] CMD_CNT_PFX   = 8'h84;
  // Temperature span in whole degrees, two's complement.
  localparam logic [7:0] DEG_MIN       = 8'hc9;
  localparam logic [7:0] DEG_MAX       = 8'h7d;
  localparam logic [7:0] DEG_ONE       = 8'h01;
  // Counter preload for the lowest degree and slope accumulator law.
  localparam logic [8:0] CNT_BASE      = 9'h0c8;
  localparam logic [8:0] SLOPE_BASE    = 9'h040;
  localparam logic [8:0] SLOPE_STEP    = 9'h001;
  localparam logic [8:0] CNT_ONE       = 9'h001;
  localparam logic [8:0] HALF_ONE      = 9'h001;
  localparam logic [8:0] HALF_TWO      = 9'h002;
  // Command set variants.
  typedef enum logic [1:0] {
    GCTC_V9  = 2'h0,
    GCTC_V8  = 2'h1,
    GCTC_VBM = 2'h2
  } gctc_var_t;
  // Host operations.
  typedef enum logic [1:0] {
    GCTC_OP_START = 2'h0,
    GCTC_OP_TEMP  = 2'h1,
    GCTC_OP_CNT   = 2'h2,
    GCTC_OP_LOAD  = 2'h3
  } gctc_op_t;
endpackage

// [gctc_if.sv]
// Byte command channel between host controller and converter.
`timescale 1ns/1ps
interface gctc_if;
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       rsp_valid;
  logic [8:0] rsp_data;
  logic       conv_done;
  modport dev (input cmd_valid, input cmd_byte, output rsp_valid, output rsp_data,
               output conv_done);
  modport hst (output cmd_valid, output cmd_byte, input rsp_valid, input rsp_data,
               input conv_done);
endinterface

// [gctc_host.sv]
// Host end: turns operation requests into command bytes and collects answers.
`timescale 1ns/1ps
module gctc_host
  import gctc_pkg::*;
(
  input  wire logic       clk,       // System clock.
  input  wire logic       sys_rst,   // Synchronous reset, active high.
  input  wire logic       ce,        // Clock enable, freezes all state when low.
  input  wire gctc_var_t  variant,   // Command set in use.
  input  wire logic       req_valid, // Operation request.
  input  wire gctc_op_t   req_op,    // Operation to perform.
  output logic            req_ready, // Idle and able to take a request.
  output logic            res_valid, // One-cycle pulse with a read result.
  output logic [8:0]      res_data,  // Read result.
  output logic            done,      // Last conversion finished.
  gctc_if.hst             bus        // Command channel.
);
  typedef enum logic [1:0] {
    GCTC_H_IDLE = 2'b00,
    GCTC_H_WAIT = 2'b01,
    GCTC_H_SEND = 2'b11,
    GCTC_H_RSP  = 2'b10
  } gctc_hst_t;

  gctc_hst_t  st_r;
  gctc_op_t   op_r;
  logic       two_r;
  logic [7:0] b2_r;
  logic       cv_r;
  logic [7:0] cb_r;
  logic       rv_r;
  logic [8:0] rd_r;
  logic       done_r;

  wire is_bm    = (variant == GCTC_VBM);
  wire [7:0] first_b = (req_op == GCTC_OP_START) ? (is_bm ? CMD_START_BM : CMD_START) :
                       (req_op == GCTC_OP_TEMP)  ? (is_bm ? CMD_TEMP_PFX : CMD_RD_TEMP) :
                       (req_op == GCTC_OP_CNT)   ? (is_bm ? CMD_CNT_PFX : CMD_RD_CNT) :
                       (is_bm ? CMD_CNT_PFX : CMD_LOAD_CNT);
  wire [7:0] second_b = (req_op == GCTC_OP_TEMP) ? CMD_TEMP_BM :
                        (req_op == GCTC_OP_CNT) ? CMD_RD_CNT : CMD_LOAD_CNT;
  wire       two_b    = is_bm && (req_op != GCTC_OP_START);
  wire       is_read  = (op_r == GCTC_OP_TEMP) || (op_r == GCTC_OP_CNT);
  wire       take     = (st_r == GCTC_H_IDLE) && req_valid;
  wire       may_go   = (op_r != GCTC_OP_TEMP) || bus.conv_done;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= GCTC_H_IDLE;
      op_r <= GCTC_OP_START;
      two_r <= 1'b0;
      b2_r <= 8'h00;
      cv_r <= 1'b0;
      cb_r <= 8'h00;
      rv_r <= 1'b0;
      rd_r <= 9'h000;
      done_r <= 1'b0;
    end else if (ce) begin
      cv_r <= 1'b0;
      rv_r <= 1'b0;
      done_r <= bus.conv_done;
      case (st_r)
        GCTC_H_IDLE: begin
          if (take) begin
            op_r <= req_op;
            two_r <= two_b;
            b2_r <= second_b;
            cb_r <= first_b;
            st_r <= GCTC_H_WAIT;
          end
        end
        GCTC_H_WAIT: begin
          if (may_go) begin
            cv_r <= 1'b1;
            st_r <= two_r ? GCTC_H_SEND : (is_read ? GCTC_H_RSP : GCTC_H_IDLE);
          end
        end
        GCTC_H_SEND: begin
          cv_r <= 1'b1;
          cb_r <= b2_r;
          st_r <= is_read ? GCTC_H_RSP : GCTC_H_IDLE;
        end
        GCTC_H_RSP: begin
          if (bus.rsp_valid) begin
            rv_r <= 1'b1;
            rd_r <= bus.rsp_data;
            st_r <= GCTC_H_IDLE;
          end
        end
        default: begin
          st_r <= GCTC_H_IDLE;
        end
      endcase
    end
  end

  assign req_ready     = (st_r == GCTC_H_IDLE);
  assign bus.cmd_valid = cv_r;
  assign bus.cmd_byte  = cb_r;
  assign res_valid     = rv_r;
  assign res_data      = rd_r;
  assign done          = done_r;
endmodule

// [gctc_monitor.sv]
// Checker watching the command channel between the two ends.
`timescale 1ns/1ps
module gctc_monitor
  import gctc_pkg::*;
(
  input wire logic       clk,       // System clock.
  input wire logic       sys_rst,   // Synchronous reset.
  input wire logic       cmd_valid, // Byte strobe.
  input wire logic [7:0] cmd_byte,  // Command byte.
  input wire logic       rsp_valid, // Answer strobe.
  input wire logic [8:0] rsp_data,  // Answer value.
  input wire logic       conv_done  // Conversion finished.
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_rd_cnt;
    cmd_valid && cmd_byte == CMD_RD_CNT;
  endsequence
  sequence s_rd_temp;
    cmd_valid && (cmd_byte == CMD_RD_TEMP || cmd_byte == CMD_TEMP_BM);
  endsequence
  sequence s_start;
    cmd_valid && (cmd_byte == CMD_START || cmd_byte == CMD_START_BM);
  endsequence
  a_cnt_answer: assert property (s_rd_cnt |=> rsp_valid)
    else $error("no answer to counter read");
  a_temp_answer: assert property (s_rd_temp |=> rsp_valid)
    else $error("no answer to temperature read");
  a_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without a command byte");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe longer than one cycle");
  a_data_holds: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("answer value changed without a read");
  a_done_holds: assert property (conv_done && !cmd_valid |=> conv_done)
    else $error("completion flag dropped");
  a_start_clears: assert property (s_start |-> ##[1:2] !conv_done)
    else $error("start left completion flag set");
  // Signed half-degree span, also covers whole-degree readings.
  a_temp_span: assert property (s_rd_temp ##1 rsp_valid |->
    $signed(rsp_data) >= -110 && $signed(rsp_data) <= 250)
    else $error("temperature outside span");
endmodule

// [gated_count_temp_converter_tb.sv]
// Self-checking bench joining the host and converter ends.
`timescale 1ns/1ps
module gated_count_temp_converter_tb
  import gctc_pkg::*;
;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       ce = 1'b1;
  logic       ref_tick = 1'b0;
  logic       gate = 1'b0;
  logic       req_valid = 1'b0;
  gctc_var_t  variant = GCTC_V9;
  gctc_op_t   req_op = GCTC_OP_START;
  logic       busy;
  logic       req_ready;
  logic       res_valid;
  logic       done;
  logic [8:0] res_data;
  int         miscompares = 0;
  int         comparisons = 0;
  int         cycles = 0;

  gctc_if u_gctc_if ();
  gctc_dev u_gctc_dev (.clk(clk), .sys_rst(sys_rst), .ce(ce), .ref_tick(ref_tick),
    .gate(gate), .variant(variant), .busy(busy), .bus(u_gctc_if));
  gctc_host u_gctc_host (.clk(clk), .sys_rst(sys_rst), .ce(ce), .variant(variant),
    .req_valid(req_valid), .req_op(req_op), .req_ready(req_ready),
    .res_valid(res_valid), .res_data(res_data), .done(done), .bus(u_gctc_if));
  gctc_monitor u_gctc_monitor (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(u_gctc_if.cmd_valid), .cmd_byte(u_gctc_if.cmd_byte),
    .rsp_valid(u_gctc_if.rsp_valid), .rsp_data(u_gctc_if.rsp_data),
    .conv_done(u_gctc_if.conv_done));

  always #5 clk = ~clk;

  task automatic finish_test;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Longest run is a few thousand cycles, so this only trips on a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finish_test;
    end
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic req(input gctc_op_t op);
    while (!req_ready) @(negedge clk);
    req_valid = 1'b1;
    req_op = op;
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  // A missing strobe turns the result unknown so it can never match.
  task automatic rd(input gctc_op_t op, input logic [8:0] exp);
    int i;
    req(op);
    for (i = 0; i < 50 && res_valid !== 1'b1; i++) @(negedge clk);
    chk(res_valid === 1'b1 ? res_data : 9'bx, exp);
  endtask

  // Ticks come every other cycle so each one is a separate pulse.
  task automatic conv(input gctc_var_t v, input int n, input bit rst);
    if (rst) begin
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
    end
    variant = v;
    req(GCTC_OP_START);
    while (!busy) @(negedge clk);
    gate = 1'b1;
    // The converter needs one edge to leave the arm state, or the first tick is lost.
    @(negedge clk);
    repeat (n) begin
      ref_tick = 1'b1;
      @(negedge clk);
      ref_tick = 1'b0;
      @(negedge clk);
    end
    gate = 1'b0;
    while (done !== 1'b1) @(negedge clk);
    chk({8'h00, busy}, 9'h000);
  endtask

  // One step then half a slope: half bit set, load gives the new slope.
  task automatic t_half;
    conv(GCTC_V9, 233, 1'b1);
    rd(GCTC_OP_TEMP, 9'h195);
    req(GCTC_OP_LOAD);
    rd(GCTC_OP_CNT, 9'h041);
  endtask

  // Without reset, start alone must preset both counter and temperature.
  task automatic t_base;
    conv(GCTC_V9, 5, 1'b0);
    rd(GCTC_OP_TEMP, 9'h192);
    rd(GCTC_OP_CNT, 9'h0c3);
  endtask

  task automatic t_round;
    gctc_var_t  vs[3] = '{GCTC_V9, GCTC_V8, GCTC_VBM};
    logic [8:0] ex[3] = '{9'h196, 9'h1cb, 9'h196};
    for (int i = 0; i < 3; i++) begin
      conv(vs[i], 251, 1'b1);
      rd(GCTC_OP_TEMP, ex[i]);
      req(GCTC_OP_LOAD);
      rd(GCTC_OP_CNT, 9'h041);
    end
  endtask

  // Ticks while the clock enable is low must leave the counter untouched.
  task automatic t_freeze;
    variant = GCTC_V9;
    req(GCTC_OP_START);
    while (!busy) @(negedge clk);
    gate = 1'b1;
    @(negedge clk);
    ce = 1'b0;
    ref_tick = 1'b1;
    repeat (3) @(negedge clk);
    ce = 1'b1;
    ref_tick = 1'b0;
    @(negedge clk);
    ref_tick = 1'b1;
    @(negedge clk);
    ref_tick = 1'b0;
    @(negedge clk);
    gate = 1'b0;
    while (done !== 1'b1) @(negedge clk);
    rd(GCTC_OP_CNT, 9'h0c7);
  endtask

  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_half;
    t_base;
    t_round;
    t_freeze;
    finish_test;
  end
endmodule
